// File: design/asm_fifo.sv
// asm_fifo: flip-flop fifo with valid/ready on both sides and a level.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module asm_fifo #(
	parameter int W     = 64,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// fill side
	input  wire logic                     in_valid,
	output logic                          in_ready,
	input  wire logic [W-1:0]             in_data,
	// drain side
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic [W-1:0]                  out_data,
	// occupancy
	output logic [$clog2(DEPTH):0]        level
);
	localparam int AW = $clog2(DEPTH);

	logic [DEPTH-1:0][W-1:0] mem_ff, nxt_mem;
	logic [AW:0]             wr_ff, nxt_wr, rd_ff, nxt_rd;
	logic                    push, pop;

	assign level     = wr_ff - rd_ff;
	assign in_ready  = (level != (AW+1)'(DEPTH));
	assign out_valid = (wr_ff != rd_ff);
	assign out_data  = mem_ff[rd_ff[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		nxt_mem = mem_ff;
		nxt_wr  = wr_ff;
		nxt_rd  = rd_ff;
		if (push) begin
			nxt_mem[wr_ff[AW-1:0]] = in_data;
			nxt_wr = wr_ff + 1'b1;
		end
		if (pop) begin
			nxt_rd = rd_ff + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mem_ff <= '0;
			wr_ff  <= '0;
			rd_ff  <= '0;
		end else begin
			mem_ff <= nxt_mem;
			wr_ff  <= nxt_wr;
			rd_ff  <= nxt_rd;
		end
	end

endmodule // asm_fifo

// File: design/asm_slot_mapper.sv
// asm_slot_mapper: places four record channels into serial audio slots.
// assumes an AXI4-Lite master and a sample source that pushes whole frames.
`timescale 1ns/1ps

// Summary of operation
// - a channel whose pin select is clear goes out on the primary pin.
// - a channel whose pin select is set goes out on the secondary pin.
// - in TDM the channel uses the slot equal to its 6-bit slot number.
// - in I2S or left-justified mode, slots 0 to 31 sit in the left half.
// - in I2S or left-justified mode, slots 32 to 63 map to right slot n-32.
// - each channel byte holds slot in bits 5:0, pin in bit 6, bit 7 reads 0.
// - after reset channels one to four sit in slots 0 to 3 on the primary.
// - channel two, three and four bytes sit at consecutive word indices.
// - unoccupied bit cycles drive zero or release the pin by fill mode.
module asm_slot_mapper (
	// clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// axi4-lite write
	input  wire logic [asm_pkg::ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	// axi4-lite read
	input  wire logic [asm_pkg::ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// sample frames in
	input  wire logic                          smp_valid,
	output logic                               smp_ready,
	input  wire asm_pkg::asm_frame_s           smp_data,
	// serial audio port
	output logic                               bit_clk,
	output logic                               frame_sync,
	output logic                               primary_serial_out,
	output logic                               primary_serial_oe,
	output logic                               general_pin_one_out,
	output logic                               general_pin_one_oe
);

	////////////////////////////////////////////////////////////////////////
	// register bus
	asm_pkg::asm_chcfg_s [3:0]         cfg_ff, nxt_cfg;
	logic [7:0]                        ctrl_ff, nxt_ctrl;
	logic                              undr_ff, nxt_undr;
	logic                              aw_got_ff, nxt_aw_got;
	logic                              w_got_ff, nxt_w_got;
	logic [5:0]                        widx_ff, nxt_widx;
	logic [31:0]                       wdat_ff, nxt_wdat;
	logic [3:0]                        wstb_ff, nxt_wstb;
	logic                              bvalid_ff, nxt_bvalid;
	logic [1:0]                        bresp_ff, nxt_bresp;
	logic                              rvalid_ff, nxt_rvalid;
	logic [1:0]                        rresp_ff, nxt_rresp;
	logic [31:0]                       rdata_ff, nxt_rdata;
	logic [5:0]                        ridx_ff, nxt_ridx;
	logic                              wr_do, underrun;
	logic [5:0]                        ar_idx;
	logic [$clog2(asm_pkg::FIFO_DEPTH):0] fifo_lvl;

	function automatic logic is_mapped(input logic [5:0] idx);
		is_mapped = (idx == asm_pkg::IDX_CH1) || (idx == asm_pkg::IDX_CH2) ||
			(idx == asm_pkg::IDX_CH3) || (idx == asm_pkg::IDX_CH4) ||
			(idx == asm_pkg::IDX_CTRL) || (idx == asm_pkg::IDX_STAT);
	endfunction

	assign s_axi_awready = !aw_got_ff && !bvalid_ff;
	assign s_axi_wready  = !w_got_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = rdata_ff;
	assign wr_do         = aw_got_ff && w_got_ff;
	assign ar_idx        = s_axi_araddr[7:2];

	always_comb begin
		nxt_aw_got = aw_got_ff;
		nxt_w_got  = w_got_ff;
		nxt_widx   = widx_ff;
		nxt_wdat   = wdat_ff;
		nxt_wstb   = wstb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp  = bresp_ff;
		nxt_cfg    = cfg_ff;
		nxt_ctrl   = ctrl_ff;
		nxt_undr   = undr_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw_got = 1'b1;
			nxt_widx   = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w_got = 1'b1;
			nxt_wdat  = s_axi_wdata;
			nxt_wstb  = s_axi_wstrb;
		end
		if (wr_do) begin
			nxt_aw_got = 1'b0;
			nxt_w_got  = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp  = is_mapped(widx_ff) ? asm_pkg::RESP_OK
				: asm_pkg::RESP_ERR;
			// only the low byte lane carries register bits
			if (wstb_ff[0]) begin
				case (widx_ff)
				asm_pkg::IDX_CH1: nxt_cfg[0] = wdat_ff[6:0];
				asm_pkg::IDX_CH2: nxt_cfg[1] = wdat_ff[6:0];
				asm_pkg::IDX_CH3: nxt_cfg[2] = wdat_ff[6:0];
				asm_pkg::IDX_CH4: nxt_cfg[3] = wdat_ff[6:0];
				asm_pkg::IDX_CTRL: nxt_ctrl = {4'h0, wdat_ff[3:0]};
				asm_pkg::IDX_STAT: begin
					if (wdat_ff[asm_pkg::UNDR_BIT])
						nxt_undr = 1'b0;
				end
				default: ;
				endcase
			end
		end
		if (s_axi_bvalid && s_axi_bready)
			nxt_bvalid = 1'b0;
		// a new underrun beats a clear in the same cycle
		if (underrun)
			nxt_undr = 1'b1;
	end

	always_comb begin
		nxt_rvalid = rvalid_ff;
		nxt_rresp  = rresp_ff;
		nxt_rdata  = rdata_ff;
		nxt_ridx   = ridx_ff;
		if (s_axi_rvalid && s_axi_rready)
			nxt_rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_ridx   = ar_idx;
			nxt_rresp  = is_mapped(ar_idx) ? asm_pkg::RESP_OK
				: asm_pkg::RESP_ERR;
			case (ar_idx)
			asm_pkg::IDX_CH1: nxt_rdata = {25'h0, cfg_ff[0]};
			asm_pkg::IDX_CH2: nxt_rdata = {25'h0, cfg_ff[1]};
			asm_pkg::IDX_CH3: nxt_rdata = {25'h0, cfg_ff[2]};
			asm_pkg::IDX_CH4: nxt_rdata = {25'h0, cfg_ff[3]};
			asm_pkg::IDX_CTRL: nxt_rdata = {24'h0, ctrl_ff};
			asm_pkg::IDX_STAT: nxt_rdata = {19'h0, fifo_lvl, 7'h0, undr_ff};
			default: nxt_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_ff[0] <= asm_pkg::CH1_RST[6:0];
			cfg_ff[1] <= asm_pkg::CH2_RST[6:0];
			cfg_ff[2] <= asm_pkg::CH3_RST[6:0];
			cfg_ff[3] <= asm_pkg::CH4_RST[6:0];
			ctrl_ff   <= asm_pkg::CTRL_RST;
			undr_ff   <= 1'b0;
			aw_got_ff <= 1'b0;
			w_got_ff  <= 1'b0;
			widx_ff   <= 6'h00;
			wdat_ff   <= 32'h0;
			wstb_ff   <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= 2'h0;
			rvalid_ff <= 1'b0;
			rresp_ff  <= 2'h0;
			rdata_ff  <= 32'h0;
			ridx_ff   <= 6'h00;
		end else begin
			cfg_ff    <= nxt_cfg;
			ctrl_ff   <= nxt_ctrl;
			undr_ff   <= nxt_undr;
			aw_got_ff <= nxt_aw_got;
			w_got_ff  <= nxt_w_got;
			widx_ff   <= nxt_widx;
			wdat_ff   <= nxt_wdat;
			wstb_ff   <= nxt_wstb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff  <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rresp_ff  <= nxt_rresp;
			rdata_ff  <= nxt_rdata;
			ridx_ff   <= nxt_ridx;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sample fifo: frames are popped one per serial frame
	asm_pkg::asm_frame_s fifo_data;
	logic                fifo_valid, fifo_pop;

	asm_fifo #(
		.W     ($bits(asm_pkg::asm_frame_s)),
		.DEPTH (asm_pkg::FIFO_DEPTH)
	) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (smp_valid),
		.in_ready  (smp_ready),
		.in_data   (smp_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data),
		.level     (fifo_lvl)
	);

	////////////////////////////////////////////////////////////////////////
	// bit clock divider and frame counter
	logic [3:0]                      div_ff, nxt_div;
	logic [asm_pkg::CNT_W-1:0]       cnt_ff, nxt_cnt;
	asm_pkg::asm_frame_s             frame_ff, nxt_frame;
	logic                            bclk_ff, nxt_bclk;
	logic                            port_en, fill_hiz, bit_en, frame_end;
	logic [1:0]                      fmt;

	assign port_en   = ctrl_ff[asm_pkg::EN_BIT];
	assign fill_hiz  = ctrl_ff[asm_pkg::FILL_BIT];
	assign fmt       = ctrl_ff[asm_pkg::FMT_LSB +: 2];
	assign bit_en    = port_en && (div_ff == asm_pkg::DIV_LAST);
	assign frame_end = bit_en && (cnt_ff == asm_pkg::CNT_LAST);
	assign fifo_pop  = frame_end && fifo_valid;
	assign underrun  = frame_end && !fifo_valid;

	always_comb begin
		nxt_div   = div_ff;
		nxt_cnt   = cnt_ff;
		nxt_frame = frame_ff;
		if (!port_en) begin
			nxt_div = 4'h0;
			nxt_cnt = '0;
		end else if (bit_en) begin
			nxt_div = 4'h0;
			nxt_cnt = cnt_ff + 1'b1;
		end else begin
			nxt_div = div_ff + 1'b1;
		end
		// an empty fifo sends a silent frame rather than stale data
		if (frame_end)
			nxt_frame = fifo_valid ? fifo_data : '0;
		// high in the second half of each bit so the edge lands mid-bit
		nxt_bclk = port_en && (nxt_div >= asm_pkg::DIV_HALF);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_ff   <= 4'h0;
			cnt_ff   <= '0;
			frame_ff <= '0;
			bclk_ff  <= 1'b0;
		end else begin
			div_ff   <= nxt_div;
			cnt_ff   <= nxt_cnt;
			frame_ff <= nxt_frame;
			bclk_ff  <= nxt_bclk;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// slot match per channel and pin steering
	logic [3:0]  hit, hit_prim, hit_sec;
	logic [3:0]  bit_idx;
	logic        prim_bit, sec_bit, prim_any, sec_any;
	logic        half_right;
	logic [4:0]  half_slot;

	assign bit_idx    = 4'hf - cnt_ff[3:0];
	assign half_right = cnt_ff[9];
	assign half_slot  = cnt_ff[8:4];

	for (genvar c = 0; c < asm_pkg::NUM_CH; c++) begin : g_ch
		always_comb begin
			if (fmt == asm_pkg::FMT_I2S || fmt == asm_pkg::FMT_LEFT) begin
				// upper half of the slot range maps to the right half-frame
				hit[c] = (cfg_ff[c].slot[5] == half_right) &&
					(cfg_ff[c].slot[4:0] == half_slot);
			end else begin
				hit[c] = (cfg_ff[c].slot == cnt_ff[9:4]);
			end
		end
		assign hit_prim[c] = port_en && hit[c] && !cfg_ff[c].pin_sel;
		assign hit_sec[c]  = port_en && hit[c] && cfg_ff[c].pin_sel;
	end

	// overlapping slots on one pin: the lowest channel wins
	always_comb begin
		prim_bit = 1'b0;
		sec_bit  = 1'b0;
		for (int c = asm_pkg::NUM_CH - 1; c >= 0; c--) begin
			if (hit_prim[c])
				prim_bit = frame_ff.smp[c][bit_idx];
			if (hit_sec[c])
				sec_bit = frame_ff.smp[c][bit_idx];
		end
	end

	assign prim_any = |hit_prim;
	assign sec_any  = |hit_sec;

	////////////////////////////////////////////////////////////////////////
	// output pins
	logic prim_out_ff, nxt_prim_out, prim_oe_ff, nxt_prim_oe;
	logic sec_out_ff, nxt_sec_out, sec_oe_ff, nxt_sec_oe;
	logic fsync_ff, nxt_fsync;

	always_comb begin
		nxt_prim_out = prim_any && prim_bit;
		nxt_prim_oe  = prim_any || !fill_hiz;
		nxt_sec_out  = sec_any && sec_bit;
		nxt_sec_oe   = sec_any || !fill_hiz;
		case (fmt)
		asm_pkg::FMT_I2S:  nxt_fsync = port_en && half_right;
		asm_pkg::FMT_LEFT: nxt_fsync = port_en && !half_right;
		default:           nxt_fsync = port_en && (cnt_ff == '0);
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prim_out_ff <= 1'b0;
			prim_oe_ff  <= 1'b0;
			sec_out_ff  <= 1'b0;
			sec_oe_ff   <= 1'b0;
			fsync_ff    <= 1'b0;
		end else begin
			prim_out_ff <= nxt_prim_out;
			prim_oe_ff  <= nxt_prim_oe;
			sec_out_ff  <= nxt_sec_out;
			sec_oe_ff   <= nxt_sec_oe;
			fsync_ff    <= nxt_fsync;
		end
	end

	assign bit_clk             = bclk_ff;
	assign frame_sync          = fsync_ff;
	assign primary_serial_out  = prim_out_ff;
	assign primary_serial_oe   = prim_oe_ff;
	assign general_pin_one_out = sec_out_ff;
	assign general_pin_one_oe  = sec_oe_ff;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	prim_pin_a: assert property (
		(port_en && hit[0] && !cfg_ff[0].pin_sel)
		|=> primary_serial_oe && primary_serial_out ==
			$past(frame_ff.smp[0][bit_idx]))
		else $error("channel one missing on primary pin");

	sec_pin_a: assert property (
		(|hit_sec && !prim_any && fill_hiz)
		|=> general_pin_one_oe && !primary_serial_oe)
		else $error("secondary channel not moved off primary pin");

	tdm_slot_a: assert property (
		(port_en && fmt == asm_pkg::FMT_TDM && !hit_prim[0] &&
		!hit_prim[1] && !cfg_ff[2].pin_sel &&
		cfg_ff[2].slot == cnt_ff[9:4])
		|=> primary_serial_out == $past(frame_ff.smp[2][bit_idx]))
		else $error("tdm slot mismatch for channel three");

	left_half_a: assert property (
		(port_en && fmt == asm_pkg::FMT_LEFT && hit_prim[0] &&
		!cfg_ff[0].slot[5]) |=> frame_sync && primary_serial_oe)
		else $error("left slot sent outside left half");

	right_half_a: assert property (
		(port_en && fmt == asm_pkg::FMT_LEFT && hit_prim[1] &&
		cfg_ff[1].slot[5]) |=> !frame_sync && primary_serial_oe)
		else $error("right slot sent outside right half");

	rsvd_bit_a: assert property (
		(rvalid_ff && ridx_ff >= asm_pkg::IDX_CH1 &&
		ridx_ff <= asm_pkg::IDX_CH4) |-> (s_axi_rdata[31:7] == 25'h0))
		else $error("channel byte reads nonzero upper bits");

	reset_map_a: assert property (
		!$past(aresetn) |-> cfg_ff[0] == 7'h00 && cfg_ff[1] == 7'h01 &&
		cfg_ff[2] == 7'h02 && cfg_ff[3] == 7'h03)
		else $error("channel defaults wrong after reset");

	ch_addr_a: assert property (
		(wr_do && wstb_ff[0] && widx_ff == asm_pkg::IDX_CH3)
		|=> cfg_ff[2] == $past(wdat_ff[6:0]) ##1 s_axi_bresp == 2'h0)
		else $error("channel three byte not written");

	// gated by reset so the release edge is not judged on reset outputs
	fill_mode_a: assert property (
		(aresetn && !prim_any) |=> !primary_serial_out &&
		primary_serial_oe == !$past(fill_hiz))
		else $error("unused cycle fill wrong");

endmodule // asm_slot_mapper

// File: include/asm_pkg.sv
// asm_pkg: constants and carrier types of the audio channel slot mapper.
// assumes a 25 MHz aclk and a 32-bit AXI4-Lite register bus.
package asm_pkg;

	////////////////////////////////////////////////////////////////////////
	// register map: word index, byte address is four times the index
	localparam int            ADDR_W   = 8;
	localparam logic [5:0]    IDX_CH1  = 6'h0b;
	localparam logic [5:0]    IDX_CH2  = 6'h0c;
	localparam logic [5:0]    IDX_CH3  = 6'h0d;
	localparam logic [5:0]    IDX_CH4  = 6'h0e;
	localparam logic [5:0]    IDX_CTRL = 6'h10;
	localparam logic [5:0]    IDX_STAT = 6'h11;

	// per-channel byte: slot number and pin select
	localparam int            SLOT_LSB = 0;
	localparam int            SLOT_W   = 6;
	localparam int            PIN_BIT  = 6;
	localparam logic [7:0]    CH1_RST  = 8'h00;
	localparam logic [7:0]    CH2_RST  = 8'h01;
	localparam logic [7:0]    CH3_RST  = 8'h02;
	localparam logic [7:0]    CH4_RST  = 8'h03;

	// port control byte
	localparam int            FMT_LSB  = 0;
	localparam int            FILL_BIT = 2;
	localparam int            EN_BIT   = 3;
	localparam logic [7:0]    CTRL_RST = 8'h00;
	localparam logic [1:0]    FMT_TDM  = 2'h0;
	localparam logic [1:0]    FMT_I2S  = 2'h1;
	localparam logic [1:0]    FMT_LEFT = 2'h2;

	// status word
	localparam int            UNDR_BIT = 0;
	localparam int            LVL_LSB  = 8;

	localparam logic [1:0]    RESP_OK  = 2'h0;
	localparam logic [1:0]    RESP_ERR = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// frame geometry and timing
	localparam int            NUM_CH     = 4;
	localparam int            SAMPLE_W   = 16;
	localparam int            NUM_SLOTS  = 64;
	localparam int            FIFO_DEPTH = 16;
	localparam int            CNT_W      = 10;
	localparam logic [9:0]    CNT_LAST   = 10'h3ff;
	localparam int            CLK_HZ     = 25_000_000;
	localparam int            BCLK_HZ    = 6_250_000;
	localparam int            BCLK_HALF  = CLK_HZ / (2 * BCLK_HZ);
	localparam logic [3:0]    DIV_HALF   = 4'(BCLK_HALF);
	localparam logic [3:0]    DIV_LAST   = 4'(2 * BCLK_HALF - 1);

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic                  pin_sel;
		logic [SLOT_W-1:0]     slot;
	} asm_chcfg_s;

	typedef struct packed {
		logic [NUM_CH-1:0][SAMPLE_W-1:0] smp;
	} asm_frame_s;

endpackage

// File: verification/asm_frame_receiver.sv
// asm_frame_receiver: far-end model that captures serial audio frames.
// assumes bit_clk idles low and data pins are settled at its rise.
`timescale 1ns/1ps
module asm_frame_receiver (
	// serial port
	input  wire logic          bit_clk,
	input  wire logic          frame_sync,
	input  wire logic          sync_on_fall,
	input  wire logic          pri_d,
	input  wire logic          pri_oe,
	input  wire logic          sec_d,
	input  wire logic          sec_oe,
	// last complete frame
	output logic [1023:0]      pri_bits,
	output logic [1023:0]      pri_drv,
	output logic [1023:0]      sec_bits,
	output logic [1023:0]      sec_drv,
	output logic [15:0]        frames
);
	logic [1023:0] pw;
	logic [1023:0] pd;
	logic [1023:0] sw;
	logic [1023:0] sd;
	logic [10:0]   idx  = 11'h7ff;
	logic          fs_q = 1'b0;

	initial frames = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// parked at 7ff after each complete frame until the next frame start; a clock
	// stopped mid-frame resumes at the same index when it restarts
	always @(posedge bit_clk) begin
		if (sync_on_fall ? (fs_q && !frame_sync) : (!fs_q && frame_sync))
			idx = 11'h000;
		if (idx < 11'h400) begin
			pw[idx] = pri_d;
			pd[idx] = pri_oe;
			sw[idx] = sec_d;
			sd[idx] = sec_oe;
			if (idx == 11'h3ff) begin
				pri_bits <= pw;
				pri_drv  <= pd;
				sec_bits <= sw;
				sec_drv  <= sd;
				frames   <= frames + 16'h0001;
				idx = 11'h7ff;
			end else begin
				idx = idx + 11'h001;
			end
		end
		fs_q = frame_sync;
	end
endmodule // asm_frame_receiver

// File: verification/tb_asm_slot_mapper.sv
// tb_asm_slot_mapper: self-checking bench of the slot mapper.
// assumes asm_pkg, the design and the receiver model are compiled first.
`timescale 1ns/1ps
module tb_asm_slot_mapper;
	localparam logic [63:0] FRAME = 64'h4d04c3032b028e01;
	localparam logic [1:0]  OK    = asm_pkg::RESP_OK;

	logic                   aclk          = 1'b0;
	logic                   aresetn       = 1'b0;
	logic [7:0]             s_axi_awaddr  = 8'h00;
	logic                   s_axi_awvalid = 1'b0;
	logic                   s_axi_awready;
	logic [31:0]            s_axi_wdata   = 32'h00000000;
	logic [3:0]             s_axi_wstrb   = 4'hf;
	logic                   s_axi_wvalid  = 1'b0;
	logic                   s_axi_wready;
	logic [1:0]             s_axi_bresp;
	logic                   s_axi_bvalid;
	logic                   s_axi_bready  = 1'b0;
	logic [7:0]             s_axi_araddr  = 8'h00;
	logic                   s_axi_arvalid = 1'b0;
	logic                   s_axi_arready;
	logic [31:0]            s_axi_rdata;
	logic [1:0]             s_axi_rresp;
	logic                   s_axi_rvalid;
	logic                   s_axi_rready  = 1'b0;
	logic                   smp_valid     = 1'b0;
	logic                   smp_ready;
	asm_pkg::asm_frame_s    smp_data;
	logic                   bit_clk;
	logic                   frame_sync;
	logic                   primary_serial_out;
	logic                   primary_serial_oe;
	logic                   general_pin_one_out;
	logic                   general_pin_one_oe;
	logic                   on_fall       = 1'b0;
	logic [1023:0]          pri_bits;
	logic [1023:0]          pri_drv;
	logic [1023:0]          sec_bits;
	logic [1023:0]          sec_drv;
	logic [15:0]            frames;
	int                     error_cnt     = 0;
	int                     cmp_count     = 0;
	int                     cyc           = 0;

	asm_slot_mapper i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .smp_valid, .smp_ready,
		.smp_data, .bit_clk, .frame_sync, .primary_serial_out,
		.primary_serial_oe, .general_pin_one_out, .general_pin_one_oe);

	asm_frame_receiver i_host (.bit_clk, .frame_sync, .sync_on_fall(on_fall),
		.pri_d(primary_serial_out), .pri_oe(primary_serial_oe),
		.sec_d(general_pin_one_out), .sec_oe(general_pin_one_oe),
		.pri_bits, .pri_drv, .sec_bits, .sec_drv, .frames);

	always #20 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// nine frames of traffic need about 37k cycles
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 80000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	task automatic check_word(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [15:0] slot_of(input logic [1023:0] v,
		input int k);
		for (int i = 0; i < 16; i++)
			slot_of[15 - i] = v[16 * k + i];
	endfunction

	task automatic check_slot(input string what, input logic [1023:0] v,
		input int k, input logic [15:0] exp);
		check_word(what, {16'h0000, exp}, {16'h0000, slot_of(v, k)});
	endtask

	////////////////////////////////////////////////////////////////////////
	// handshakes judged at the falling edge, released after the rise
	task automatic axi_write(input logic [5:0] idx, input logic [31:0] d,
		input logic [1:0] er);
		logic aw;
		logic w;
		logic b;
		@(posedge aclk);
		s_axi_awaddr  <= {idx, 2'b00};
		s_axi_awvalid <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(negedge aclk);
			aw = s_axi_awvalid && s_axi_awready;
			w  = s_axi_wvalid && s_axi_wready;
			b  = s_axi_bvalid;
			if (b)
				check_word("bresp", 32'(er), 32'(s_axi_bresp));
			@(posedge aclk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end while (!b);
		s_axi_bready <= 1'b0;
	endtask

	task automatic check_reg(input string what, input logic [5:0] idx,
		input logic [31:0] exp, input logic [1:0] er, input logic [31:0] m);
		logic a;
		logic r;
		@(posedge aclk);
		s_axi_araddr  <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(negedge aclk);
			a = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid;
			if (r) begin
				check_word(what, exp, s_axi_rdata & m);
				check_word("rresp", 32'(er), 32'(s_axi_rresp));
			end
			@(posedge aclk);
			if (a)
				s_axi_arvalid <= 1'b0;
		end while (!r);
		s_axi_rready <= 1'b0;
	endtask

	task automatic capture(input logic [1:0] fmt, input logic fill);
		logic [15:0] f0;
		on_fall <= (fmt == asm_pkg::FMT_I2S);
		axi_write(asm_pkg::IDX_CTRL, {28'h0000000, 1'b1, fill, fmt}, OK);
		f0 = frames;
		while (frames < f0 + 16'h0003)
			@(posedge aclk);
		axi_write(asm_pkg::IDX_CTRL, 32'h00000000, OK);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic sc_reset_map();
		check_reg("ch1", asm_pkg::IDX_CH1, 32'h0, OK, '1);
		check_reg("ch2", 6'h0c, 32'h1, OK, '1);
		check_reg("ch3", 6'h0d, 32'h2, OK, '1);
		check_reg("ch4", 6'h0e, 32'h3, OK, '1);
		check_reg("unmapped", 6'h0f, 32'h0, asm_pkg::RESP_ERR, '1);
		axi_write(6'h0f, 32'h000000ff, asm_pkg::RESP_ERR);
	endtask

	task automatic sc_field();
		axi_write(6'h0d, 32'hffffffff, OK);
		check_reg("ch3 bits", 6'h0d, 32'h0000007f, OK, '1);
		axi_write(6'h0d, 32'h00000002, OK);
	endtask

	// fifo is filled while the port is idle and refuses the seventeenth
	task automatic sc_fill();
		int  n;
		logic ok;
		n = 0;
		@(posedge aclk);
		smp_valid <= 1'b1;
		do begin
			@(negedge aclk);
			ok = smp_ready;
			if (ok)
				n++;
			@(posedge aclk);
		end while (ok && n < 20);
		smp_valid <= 1'b0;
		check_word("frames held", 32'h00000010, 32'(n));
		check_reg("level", asm_pkg::IDX_STAT, 32'h1000, OK, 32'h1f00);
	endtask

	task automatic sc_tdm();
		axi_write(asm_pkg::IDX_CH1, 32'h0000003f, OK);
		axi_write(6'h0c, 32'h00000045, OK);
		axi_write(6'h0d, 32'h00000000, OK);
		capture(asm_pkg::FMT_TDM, 1'b0);
		check_slot("tdm ch1", pri_bits, 63, FRAME[15:0]);
		check_slot("tdm ch2", sec_bits, 5, FRAME[31:16]);
		check_slot("tdm ch2 off primary", pri_bits, 5, 16'h0000);
		check_slot("tdm ch3", pri_bits, 0, FRAME[47:32]);
		check_slot("tdm ch4", pri_bits, 3, FRAME[63:48]);
		check_slot("tdm idle level", pri_bits, 10, 16'h0000);
		check_slot("tdm idle drive", pri_drv, 10, 16'hffff);
		check_slot("tdm sec idle drive", sec_drv, 10, 16'hffff);
	endtask

	task automatic sc_half(input logic [1:0] fmt);
		axi_write(asm_pkg::IDX_CH1, 32'h0000001f, OK);
		axi_write(6'h0c, 32'h00000020, OK);
		axi_write(6'h0d, 32'h00000061, OK);
		axi_write(6'h0e, 32'h00000000, OK);
		capture(fmt, 1'b1);
		check_slot("left 31", pri_bits, 31, FRAME[15:0]);
		check_slot("right 0", pri_bits, 32, FRAME[31:16]);
		check_slot("right 1 sec", sec_bits, 33, FRAME[47:32]);
		check_slot("left 0", pri_bits, 0, FRAME[63:48]);
		check_slot("idle released", pri_drv, 10, 16'h0000);
		check_slot("busy driven", pri_drv, 31, 16'hffff);
		check_slot("sec released", sec_drv, 10, 16'h0000);
		check_slot("sec busy driven", sec_drv, 33, 16'hffff);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		smp_data = FRAME;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		sc_reset_map();
		sc_field();
		sc_fill();
		sc_tdm();
		sc_half(asm_pkg::FMT_I2S);
		sc_half(asm_pkg::FMT_LEFT);
		tally_and_finish();
	end
endmodule // tb_asm_slot_mapper
